/* hw/address_breakpoint_unit.sv */
`timescale 1ns/1ps
// Summary of operation
// RULE1: Enabled PC match raises breakpoint request
// RULE2: Finish instruction, then load soft interrupt opcode
// RULE3: Vector FFFC/FFFD, or FEFC/FEFD in monitor
// RULE4: Writing active flag breaks before next instruction
// RULE5: Opcode-address break holds instruction until return; the code lets it complete first
// RULE6: Operand-address break lets instruction complete first
// RULE7: Return from interrupt ends break state
// RULE8: Match sets active flag; software clears it
// RULE9: Match enable at bit 7, reset cleared
// RULE10: Two address bytes, cleared on reset
// RULE11: Cleared flag, same address: no rebreak
// RULE12: Software rewrites address and clears flag
// RULE13: Break state halts both timer counters
// RULE14: Watchdog disabled in break under test voltage
// RULE15: Wait-exit flag set by break, software clears
// RULE16: Wait-exit status works only in emulation
// RULE17: Flag clearing in break needs clear enable; only the status clear-on-read is gated
// RULE18: Matching stays alive during wait mode
// RULE19: Break-state indication from entry to return
module address_breakpoint_unit (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        clk_en,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [15:0] cpu_pc_addr,
   input  wire logic        cpu_opcode_fetch,
   input  wire logic        cpu_instr_done,
   input  wire logic        cpu_rti_done,
   input  wire logic        cpu_in_wait,
   input  wire logic        test_high_voltage,
   output logic             break_request,
   output logic             force_opcode,
   output logic [7:0]       forced_opcode,
   output logic [15:0]      break_vector,
   output logic             break_state,
   output logic             timer_halt,
   output logic             watchdog_disable,
   output logic             flag_clear_allow,
   output logic             wake_from_wait,
   output logic             irq
);
   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic                   match_en_r;
   logic                   active_r;
   logic [7:0]             addr_hi_r;
   logic [7:0]             addr_lo_r;
   logic                   wait_exit_r;
   logic                   clr_en_r;
   logic                   mon_mode_r;
   logic                   emu_mode_r;
   logic [2:0]             irq_stat_r;
   logic [2:0]             irq_mask_r;
   logic                   pend_r;
   logic                   pend_soft_r;
   logic                   arm_r;
   brk_pkg::brk_state_t    state_r;

   // Bus channel holding registers
   logic                   aw_ok_r;
   logic                   w_ok_r;
   logic [7:0]             aw_addr_r;
   logic [31:0]            w_data_r;
   logic [3:0]             w_strb_r;

   logic                   wr_fire;
   logic                   rd_fire;
   logic                   hit;
   logic                   match_ev;
   logic                   soft_ev;
   logic                   wait_ev;
   logic                   rd_stat;
   logic [31:0]            rd_data;
   logic [1:0]             rd_resp;

   brk_cmp_if cmp_bus ();

   // ---------------------------------------------------------------
   // Address matcher
   // ---------------------------------------------------------------
   assign cmp_bus.pc_addr = cpu_pc_addr;
   assign cmp_bus.bp_addr = {addr_hi_r, addr_lo_r};
   // Active flag masks further hits so a stale address cannot rebreak
   assign cmp_bus.enable  = match_en_r & ~active_r & arm_r; // RULE11 RULE18
   assign hit             = cmp_bus.hit;

   brk_addr_match u_match (
      .c (cmp_bus)
   );

   // ---------------------------------------------------------------
   // Write channel acceptance
   // ---------------------------------------------------------------
   assign wr_fire = aw_ok_r & w_ok_r & ~s_axi_bvalid;

   // Address and data taken independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok_r       <= 1'b0;
         w_ok_r        <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_addr_r     <= brk_pkg::RST_BYTE;
         w_data_r      <= 32'h0000_0000;
         w_strb_r      <= 4'h0;
      end else if (clk_en) begin
         s_axi_awready <= ~aw_ok_r & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_ok_r & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_r   <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_ok_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok_r   <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_ok_r <= 1'b0;
         end
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= brk_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_r > brk_pkg::OFS_IRQ_MASK || aw_addr_r[1:0] != 2'h0)
                            ? brk_pkg::RESP_SLVERR : brk_pkg::RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Break sequencing
   // ---------------------------------------------------------------
   assign match_ev = hit & (state_r == brk_pkg::ST_RUN);
   assign soft_ev  = wr_fire & w_strb_r[0] & (aw_addr_r == brk_pkg::OFS_CTRL_STATUS)
                     & w_data_r[brk_pkg::BIT_ACTIVE] & ~active_r;
   assign wait_ev  = (pend_r | match_ev) & cpu_in_wait & emu_mode_r; // RULE15 RULE16

   // Pending request waits for the instruction boundary; an operand hit
   // thus lets its instruction finish, and an opcode hit, pending one cycle later, lets it finish too
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r     <= brk_pkg::ST_RUN;
         pend_r      <= 1'b0;
         pend_soft_r <= 1'b0;
      end else if (clk_en) begin
         unique case (state_r)
            brk_pkg::ST_RUN: begin
               if (match_ev) begin
                  pend_r <= 1'b1; // RULE1
               end
               if (soft_ev) begin
                  pend_r      <= 1'b1; // RULE4
                  pend_soft_r <= 1'b1;
               end
               if (pend_r && (cpu_instr_done || cpu_in_wait)) begin
                  state_r <= brk_pkg::ST_ENTRY; // RULE2 RULE6
               end else if (pend_r && cpu_opcode_fetch && !pend_soft_r) begin
                  state_r <= brk_pkg::ST_ENTRY; // RULE5
               end
            end
            brk_pkg::ST_ENTRY: begin
               pend_r      <= 1'b0;
               pend_soft_r <= 1'b0;
               state_r     <= brk_pkg::ST_BREAK;
            end
            brk_pkg::ST_BREAK: begin
               if (cpu_rti_done) begin
                  state_r <= brk_pkg::ST_RUN; // RULE7
               end
            end
            default: state_r <= brk_pkg::ST_RUN;
         endcase
      end
   end

   // CPU-facing outputs, all registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         break_request    <= 1'b0;
         force_opcode     <= 1'b0;
         forced_opcode    <= brk_pkg::RST_BYTE;
         break_vector     <= brk_pkg::VEC_NORMAL;
         break_state      <= 1'b0;
         timer_halt       <= 1'b0;
         watchdog_disable <= 1'b0;
         flag_clear_allow <= 1'b0;
         wake_from_wait   <= 1'b0;
      end else if (clk_en) begin
         break_request    <= pend_r;                                     // RULE1
         force_opcode     <= (state_r == brk_pkg::ST_ENTRY);             // RULE2
         forced_opcode    <= brk_pkg::OPC_SOFT_IRQ;                      // RULE2
         break_vector     <= mon_mode_r ? brk_pkg::VEC_MONITOR
                                        : brk_pkg::VEC_NORMAL;           // RULE3
         break_state      <= (state_r != brk_pkg::ST_RUN);               // RULE19
         timer_halt       <= (state_r != brk_pkg::ST_RUN);               // RULE13
         watchdog_disable <= (state_r != brk_pkg::ST_RUN) & test_high_voltage; // RULE14
         // Outside break the gate is open; inside it follows the enable
         flag_clear_allow <= (state_r == brk_pkg::ST_RUN) | clr_en_r;    // RULE17
         wake_from_wait   <= pend_r & cpu_in_wait;                       // RULE18
      end
   end

   // ---------------------------------------------------------------
   // Software registers
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         match_en_r <= 1'b0; // RULE9
         addr_hi_r  <= brk_pkg::RST_BYTE; // RULE10
         addr_lo_r  <= brk_pkg::RST_BYTE; // RULE10
         clr_en_r   <= 1'b0;
         mon_mode_r <= 1'b0;
         emu_mode_r <= 1'b0;
         irq_mask_r <= 3'h0;
      end else if (clk_en && wr_fire && w_strb_r[0]) begin
         unique case (aw_addr_r)
            brk_pkg::OFS_CTRL_STATUS: match_en_r <= w_data_r[brk_pkg::BIT_MATCH_EN]; // RULE9
            brk_pkg::OFS_ADDR_HIGH:   addr_hi_r  <= w_data_r[7:0]; // RULE12
            brk_pkg::OFS_ADDR_LOW:    addr_lo_r  <= w_data_r[7:0];
            brk_pkg::OFS_FLAG_CLEAR:  clr_en_r   <= w_data_r[brk_pkg::BIT_CLR_EN];
            brk_pkg::OFS_MODE: begin
               mon_mode_r <= w_data_r[brk_pkg::BIT_MON_MODE];
               emu_mode_r <= w_data_r[brk_pkg::BIT_EMU_MODE];
            end
            brk_pkg::OFS_IRQ_MASK:    irq_mask_r <= w_data_r[2:0];
            default: ;
         endcase
      end
   end

   // Active flag: hardware set wins over a same-cycle software clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active_r <= 1'b0; // RULE8
         arm_r    <= 1'b1;
      end else if (clk_en) begin
         if (match_ev || soft_ev) begin
            active_r <= 1'b1; // RULE8
         end else if (wr_fire && w_strb_r[0] && aw_addr_r == brk_pkg::OFS_CTRL_STATUS
                      && !w_data_r[brk_pkg::BIT_ACTIVE]) begin
            active_r <= 1'b0; // RULE8
         end
         // A match disarms until a new address is written, so clearing
         // only the active flag cannot break on the same address again
         if (wr_fire && w_strb_r[0] && (aw_addr_r == brk_pkg::OFS_ADDR_HIGH
                                      || aw_addr_r == brk_pkg::OFS_ADDR_LOW)) begin
            arm_r <= 1'b1; // RULE12
         end else if (match_ev) begin
            arm_r <= 1'b0; // RULE11
         end
      end
   end

   // Wait-exit flag, set wins; only writes of zero clear it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_exit_r <= 1'b0;
      end else if (clk_en) begin
         if (wait_ev) begin
            wait_exit_r <= 1'b1; // RULE15
         end else if (wr_fire && w_strb_r[0] && aw_addr_r == brk_pkg::OFS_WAIT_STATUS
                      && !w_data_r[brk_pkg::BIT_WAIT_EXIT]) begin
            wait_exit_r <= 1'b0; // RULE15
         end
      end
   end

   // ---------------------------------------------------------------
   // Interrupt status, cleared on read (blocked in break unless enabled)
   // ---------------------------------------------------------------
   assign rd_stat = rd_fire & (s_axi_araddr == brk_pkg::OFS_IRQ_STATUS)
                    & ((state_r == brk_pkg::ST_RUN) | clr_en_r); // RULE17

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_r <= 3'h0;
         irq        <= 1'b0;
      end else if (clk_en) begin
         irq_stat_r <= (rd_stat ? 3'h0 : irq_stat_r) | {wait_ev, soft_ev, match_ev};
         irq        <= |(irq_stat_r & irq_mask_r);
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   assign rd_fire = s_axi_arvalid & s_axi_arready;

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_resp = brk_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
         brk_pkg::OFS_CTRL_STATUS: begin
            rd_data[brk_pkg::BIT_MATCH_EN] = match_en_r;
            rd_data[brk_pkg::BIT_ACTIVE]   = active_r;
         end
         brk_pkg::OFS_ADDR_HIGH:   rd_data[7:0] = addr_hi_r;
         brk_pkg::OFS_ADDR_LOW:    rd_data[7:0] = addr_lo_r;
         // Meaningless outside emulation, so it reads zero there
         brk_pkg::OFS_WAIT_STATUS: rd_data[brk_pkg::BIT_WAIT_EXIT] = wait_exit_r & emu_mode_r; // RULE16
         brk_pkg::OFS_FLAG_CLEAR:  rd_data[brk_pkg::BIT_CLR_EN]    = clr_en_r;
         brk_pkg::OFS_MODE:        rd_data[1:0] = {emu_mode_r, mon_mode_r};
         brk_pkg::OFS_IRQ_STATUS:  rd_data[2:0] = irq_stat_r;
         brk_pkg::OFS_IRQ_MASK:    rd_data[2:0] = irq_mask_r;
         default:                  rd_resp = brk_pkg::RESP_SLVERR;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= brk_pkg::RESP_OKAY;
      end else if (clk_en) begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= rd_resp;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_MATCH_REQ: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
      clk_en && match_ev |=> pend_r) else $error("match did not pend");
   AST_FORCE_OPC: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
      force_opcode |-> forced_opcode == brk_pkg::OPC_SOFT_IRQ) else $error("bad opcode");
   AST_VECTOR: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
      clk_en && mon_mode_r |=> break_vector == brk_pkg::VEC_MONITOR) else $error("vector");
   AST_SOFT_SET: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
      clk_en && soft_ev |=> active_r && pend_r) else $error("soft break lost");
   AST_RTI_END: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
      clk_en && state_r == brk_pkg::ST_BREAK && cpu_rti_done |=> state_r == brk_pkg::ST_RUN)
      else $error("return did not end break");
   AST_NO_REBREAK: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
      active_r |-> !hit) else $error("hit while active");
   AST_TIMER_HALT: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
      clk_en && state_r != brk_pkg::ST_RUN |=> timer_halt && break_state)
      else $error("timers not halted");
   AST_WDOG: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
      watchdog_disable |-> $past(test_high_voltage)) else $error("watchdog gate");
   // A status read in break without the enable must leave every bit set
   AST_CLR_GATE: assert property (@(posedge aclk) disable iff (!aresetn) // RULE17
      clk_en && rd_fire && state_r == brk_pkg::ST_BREAK && !clr_en_r
      |=> (irq_stat_r & $past(irq_stat_r)) == $past(irq_stat_r)) else $error("clear gate");
   COV_MATCH: cover property (@(posedge aclk) match_ev ##[1:20] state_r == brk_pkg::ST_BREAK);
   COV_SOFT:  cover property (@(posedge aclk) soft_ev ##[1:20] force_opcode);
   COV_RTI:   cover property (@(posedge aclk) state_r == brk_pkg::ST_BREAK ##1 cpu_rti_done);
   COV_WAIT:  cover property (@(posedge aclk) wait_ev);
endmodule // address_breakpoint_unit

/* hw/brk_addr_match.sv */
`timescale 1ns/1ps
// Per-bit equality via one generate loop, reduced to one hit
module brk_addr_match (
   brk_cmp_if.cmp c
);
   logic [15:0] eq;
   genvar i;
   generate
      for (i = 0; i < 16; i++) begin : g_bit
         assign eq[i] = (c.pc_addr[i] == c.bp_addr[i]);
      end
   endgenerate
   // Gate with enable so a disabled matcher never raises a hit
   assign c.hit = c.enable & (&eq); // RULE1
endmodule // brk_addr_match

/* hw/brk_cmp_if.sv */
`timescale 1ns/1ps
// Address comparator link between the break core and its matcher
interface brk_cmp_if;
   logic [15:0] pc_addr;
   logic [15:0] bp_addr;
   logic        enable;
   logic        hit;
   modport core (output pc_addr, output bp_addr, output enable, input hit);
   modport cmp  (input pc_addr, input bp_addr, input enable, output hit);
endinterface

/* hw/brk_pkg.sv */
package brk_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses on the register bus)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
   localparam logic [7:0] OFS_ADDR_HIGH   = 8'h04;
   localparam logic [7:0] OFS_ADDR_LOW    = 8'h08;
   localparam logic [7:0] OFS_WAIT_STATUS = 8'h0C;
   localparam logic [7:0] OFS_FLAG_CLEAR  = 8'h10;
   localparam logic [7:0] OFS_MODE        = 8'h14;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h1C;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int BIT_MATCH_EN   = 7;
   localparam int BIT_ACTIVE     = 6;
   localparam int BIT_WAIT_EXIT  = 1;
   localparam int BIT_CLR_EN     = 7;
   localparam int BIT_MON_MODE   = 0;
   localparam int BIT_EMU_MODE   = 1;
   localparam int IRQ_MATCH      = 0;
   localparam int IRQ_SOFT       = 1;
   localparam int IRQ_WAIT_EXIT  = 2;
   // ---------------------------------------------------------------
   // Reset values, vectors, opcodes
   // ---------------------------------------------------------------
   localparam logic [7:0]  RST_BYTE      = 8'h00;
   localparam logic [15:0] VEC_NORMAL    = 16'hFFFC;
   localparam logic [15:0] VEC_MONITOR   = 16'hFEFC;
   localparam logic [7:0]  OPC_SOFT_IRQ  = 8'h83;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_ENTRY = 2'b01,
      ST_BREAK = 2'b10
   } brk_state_t;
endpackage

/* test/cpu_model.sv */
`timescale 1ns/1ps
// --------------------------------------------
// CPU stand-in: two-cycle instructions
// --------------------------------------------
module cpu_model (
   input  wire logic        aclk,
   input  wire logic        force_opcode,
   input  wire logic        wake_from_wait,
   input  wire logic [15:0] break_vector,
   output logic [15:0]      pc,
   output logic             opcode_fetch,
   output logic             instr_done,
   output logic             rti_done,
   output logic             in_wait
);
   logic [15:0] base_r;
   logic        run_r;
   logic        ph_r;
   int          done_cnt;
   initial begin
      {pc, opcode_fetch, instr_done, rti_done, in_wait} = '0;
      {base_r, run_r, ph_r} = '0;
      done_cnt = 0;
   end
   // Opcode cycle then operand cycle; a forced opcode diverts to the vector
   always @(posedge aclk) begin
      if (force_opcode === 1'b1) begin
         run_r        <= 1'b0;
         pc           <= break_vector;
         in_wait      <= 1'b0;
         opcode_fetch <= 1'b0;
         instr_done   <= 1'b0;
      end else if (!run_r && in_wait && wake_from_wait === 1'b1) begin
         run_r <= 1'b1;
      end else if (run_r) begin
         ph_r         <= ~ph_r;
         pc           <= base_r + {15'h0, ph_r};
         opcode_fetch <= ~ph_r;
         instr_done   <= ph_r;
         if (ph_r) base_r <= base_r + 16'h0002;
         if (ph_r) done_cnt <= done_cnt + 1;
      end else begin
         opcode_fetch <= 1'b0;
         instr_done   <= 1'b0;
      end
   end
   // Called only while stopped, so no edge race with the process above
   task automatic go(input logic [15:0] a);
      @(posedge aclk);
      base_r <= a;
      ph_r   <= 1'b0;
      run_r  <= 1'b1;
   endtask
   task automatic stop_run();
      @(posedge aclk);
      run_r <= 1'b0;
   endtask
   task automatic return_from_interrupt_opcode(input logic [15:0] a);
      rti_done <= 1'b1;
      go(a);
      rti_done <= 1'b0;
   endtask
   task automatic park(input logic [15:0] a);
      @(posedge aclk);
      pc      <= a;
      base_r  <= a;
      ph_r    <= 1'b0;
      in_wait <= 1'b1;
   endtask
endmodule // cpu_model

/* test/test_address_breakpoint_unit.sv */
`timescale 1ns/1ps
module test_address_breakpoint_unit;
   localparam logic [1:0] OK = brk_pkg::RESP_OKAY;
   logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, test_high_voltage = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, forced_opcode, fo_code;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [15:0] cpu_pc_addr, break_vector, fo_vec;
   logic        cpu_opcode_fetch, cpu_instr_done, cpu_rti_done, cpu_in_wait;
   logic        break_request, force_opcode, break_state, timer_halt, irq;
   logic        watchdog_disable, flag_clear_allow, wake_from_wait, fo_req;
   int          err_count = 0, check_count = 0, fo_cnt = 0, fo_done = 0;

   address_breakpoint_unit i_dut (
      .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_pc_addr,
      .cpu_opcode_fetch, .cpu_instr_done, .cpu_rti_done, .cpu_in_wait,
      .test_high_voltage, .break_request, .force_opcode, .forced_opcode,
      .break_vector, .break_state, .timer_halt, .watchdog_disable,
      .flag_clear_allow, .wake_from_wait, .irq
   );
   cpu_model i_cpu (
      .aclk, .force_opcode, .wake_from_wait, .break_vector,
      .pc(cpu_pc_addr), .opcode_fetch(cpu_opcode_fetch),
      .instr_done(cpu_instr_done), .rti_done(cpu_rti_done), .in_wait(cpu_in_wait)
   );

   always #2 aclk = ~aclk;
   // Snapshot of each forced opcode pulse, which stands for one cycle only
   always @(posedge aclk) begin
      if (force_opcode === 1'b1) begin
         fo_cnt  <= fo_cnt + 1;
         fo_code <= forced_opcode;
         fo_vec  <= break_vector;
         fo_done <= i_cpu.done_cnt;
         fo_req  <= break_request;
      end
   end
   // --------------------------------------------
   // Shared tasks
   // --------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, r});
   endtask
   task automatic axr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, r});
      if (r === OK) chk(s_axi_rdata, {24'h0, d});
   endtask
   // Bounded wait, then one edge so the snapshots settle; caller judges
   task automatic wait_hi(ref logic s);
      int n;
      n = 0;
      while (s !== 1'b1 && n < 200) begin
         @(posedge aclk);
         n++;
      end
      @(posedge aclk);
   endtask
   // --------------------------------------------
   // Scenarios
   // --------------------------------------------
   task automatic s_reset();
      chk(break_vector, brk_pkg::VEC_NORMAL);
      axr(brk_pkg::OFS_CTRL_STATUS, 8'h00, OK);
      axr(brk_pkg::OFS_ADDR_LOW, 8'h00, OK);
      axr(brk_pkg::OFS_ADDR_HIGH, 8'h00, OK);
      axw(brk_pkg::OFS_ADDR_HIGH, 8'h12, OK);
      axr(brk_pkg::OFS_ADDR_HIGH, 8'h12, OK);
      axr(8'h40, 8'h00, brk_pkg::RESP_SLVERR);
   endtask
   task automatic s_match();
      axw(brk_pkg::OFS_ADDR_LOW, 8'h34, OK);
      axw(brk_pkg::OFS_IRQ_MASK, 8'h07, OK);
      axw(brk_pkg::OFS_CTRL_STATUS, 8'h80, OK);
      i_cpu.go(16'h1230);
      wait_hi(break_state);
      chk(fo_cnt, 1);
      chk(fo_code, brk_pkg::OPC_SOFT_IRQ);
      chk(fo_vec, brk_pkg::VEC_NORMAL);
      chk(fo_req, 1'b1);
      chk({timer_halt, irq, flag_clear_allow}, 3'b110);
      test_high_voltage <= 1'b1;
      axr(brk_pkg::OFS_CTRL_STATUS, 8'hC0, OK);
      chk(watchdog_disable, 1'b1);
      axr(brk_pkg::OFS_IRQ_STATUS, 8'h01, OK);
      axr(brk_pkg::OFS_IRQ_STATUS, 8'h01, OK);
      axw(brk_pkg::OFS_FLAG_CLEAR, 8'h80, OK);
      axr(brk_pkg::OFS_IRQ_STATUS, 8'h01, OK);
      axr(brk_pkg::OFS_IRQ_STATUS, 8'h00, OK);
      axw(brk_pkg::OFS_CTRL_STATUS, 8'h80, OK);
      axr(brk_pkg::OFS_CTRL_STATUS, 8'h80, OK);
      i_cpu.return_from_interrupt_opcode(16'h1234);
      repeat (20) @(posedge aclk);
      chk({break_state, timer_halt, break_request}, 3'b000);
      chk(fo_cnt, 1);
      i_cpu.stop_run();
   endtask
   task automatic s_soft();
      int d0;
      axw(brk_pkg::OFS_MODE, 8'h01, OK);
      i_cpu.go(16'h2000);
      axw(brk_pkg::OFS_CTRL_STATUS, 8'h40, OK);
      d0 = i_cpu.done_cnt;
      wait_hi(break_state);
      chk(fo_cnt, 2);
      chk(fo_done - d0 <= 1, 1);
      chk(fo_vec, brk_pkg::VEC_MONITOR);
      test_high_voltage <= 1'b0;
      axw(brk_pkg::OFS_CTRL_STATUS, 8'h00, OK);
      chk(watchdog_disable, 1'b0);
      i_cpu.return_from_interrupt_opcode(16'h2000);
      repeat (20) @(posedge aclk);
      chk(break_state, 1'b0);
      i_cpu.stop_run();
   endtask
   task automatic s_wait();
      axw(brk_pkg::OFS_MODE, 8'h02, OK);
      axw(brk_pkg::OFS_ADDR_HIGH, 8'h30, OK);
      axw(brk_pkg::OFS_ADDR_LOW, 8'h00, OK);
      axw(brk_pkg::OFS_CTRL_STATUS, 8'h80, OK);
      i_cpu.park(16'h3000);
      wait_hi(wake_from_wait);
      chk(wake_from_wait, 1'b1);
      wait_hi(break_state);
      chk({fo_cnt[7:0], fo_vec}, {8'h03, brk_pkg::VEC_NORMAL});
      axr(brk_pkg::OFS_WAIT_STATUS, 8'h02, OK);
      axw(brk_pkg::OFS_WAIT_STATUS, 8'h00, OK);
      axr(brk_pkg::OFS_WAIT_STATUS, 8'h00, OK);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Main sequence after an 8-cycle reset
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      s_reset();
      s_match();
      s_soft();
      s_wait();
      close_out();
   end
   // Watchdog: the sequence needs well under 10000 cycles
   initial begin
      #40000;
      err_count++;
      close_out();
   end
endmodule // test_address_breakpoint_unit
